// ===== hw/ocpu_match.sv
// Purpose: Timer selection and equality compare for both compare values
// Assumes: Timer counts come from logic on pclk
// Notes: Purely combinational

`timescale 1ns/100ps

module ocpu_match
  import ocpu_pkg::*;
(
  // Timer sources
  input wire logic [31:0] timer_second,
  input wire logic [31:0] timer_third,
  // Configuration
  input wire logic timebase_select,
  input wire logic wide_compare_select,
  input wire logic [31:0] primary_compare_value,
  input wire logic [31:0] secondary_compare_value,
  // Results
  output logic hit_primary,
  output logic hit_secondary
);

  logic [31:0] tmr;
  logic [31:0] mask;

  // Select timer and width of compare
  always_comb begin
    tmr = timebase_select ? timer_third : timer_second;
    mask = wide_compare_select ? 32'hffff_ffff : 32'h0000_ffff;
    hit_primary = ((tmr ^ primary_compare_value) & mask) == 32'h0000_0000;
    hit_secondary = ((tmr ^ secondary_compare_value) & mask)
                    == 32'h0000_0000;
  end

endmodule

// ===== hw/ocpu_top.sv
// Purpose: Output compare and PWM unit with an APB register slave
// Assumes: Timers and idle status are on pclk; fault pin is asynchronous
// Notes: Zero-wait APB; unmapped addresses read zero, answer OK

`timescale 1ns/100ps

module ocpu_top
  import ocpu_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer sources and system state
  input wire logic [31:0] timer_second,
  input wire logic [31:0] timer_third,
  input wire logic cpu_idle,
  // Fault pin, asynchronous
  input wire logic pwm_fault_pin,
  // Compare output pin
  output logic compare_output_pin
);

  // All state in one record
  typedef struct packed {
    ocpu_cfg_t cfg;
    logic [31:0] primary_compare_value;
    logic [31:0] secondary_compare_value;
    logic pwm_fault_status;
    logic pin;
    ocpu_phase_t phase;
    logic fault_s1;
    logic fault_s2;
    logic [31:0] rdata;
  } ocpu_state_t;

  ocpu_state_t st_r;
  ocpu_state_t st_nxt;

  logic hit_primary;
  logic hit_secondary;
  logic wr_en;
  logic rd_en;
  logic run;
  logic fault_on;
  logic [31:0] ctrl_view;

  ocpu_match u_match (
    .timer_second(timer_second),
    .timer_third(timer_third),
    .timebase_select(st_r.cfg.timebase_select),
    .wide_compare_select(st_r.cfg.wide_compare_select),
    .primary_compare_value(st_r.primary_compare_value),
    .secondary_compare_value(st_r.secondary_compare_value),
    .hit_primary(hit_primary),
    .hit_secondary(hit_secondary)
  );

  // Zero-wait slave; errors never raised
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_r.rdata;
  assign compare_output_pin = st_r.pin;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // Control word as seen by software
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[BIT_ENABLE] = st_r.cfg.enable;
    ctrl_view[BIT_STOP_IDLE] = st_r.cfg.stop_in_idle;
    ctrl_view[BIT_WIDE] = st_r.cfg.wide_compare_select;
    ctrl_view[BIT_FAULT] = st_r.pwm_fault_status &
      (st_r.cfg.compare_mode == MODE_PWM_FAULT);
    ctrl_view[BIT_TSEL] = st_r.cfg.timebase_select;
    ctrl_view[MODE_LSB +: 3] = st_r.cfg.compare_mode;
  end

  // Next-state logic for registers, pin and fault
  always_comb begin
    st_nxt = st_r;
    // Fault pin passes two flops before use
    st_nxt.fault_s1 = pwm_fault_pin;
    st_nxt.fault_s2 = st_r.fault_s1;
    run = st_r.cfg.enable & ~(st_r.cfg.stop_in_idle & cpu_idle);
    fault_on = st_r.cfg.compare_mode == MODE_PWM_FAULT;

    // Read data captured in setup, held through access
    if (rd_en) begin
      case (paddr)
        OFF_CONTROL: st_nxt.rdata = ctrl_view;
        OFF_PRIMARY: st_nxt.rdata = st_r.primary_compare_value;
        OFF_SECONDARY: st_nxt.rdata = st_r.secondary_compare_value;
        OFF_STATUS: st_nxt.rdata = {31'h0000_0000, ctrl_view[BIT_FAULT]};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Compare engine
    if (!st_r.cfg.enable || st_r.cfg.compare_mode == MODE_OFF) begin
      st_nxt.pin = 1'b0;
      st_nxt.phase = PS_IDLE;
    end else if (run) begin
      case (st_r.cfg.compare_mode)
        MODE_SET_HIGH: begin
          if (hit_primary) begin
            st_nxt.pin = 1'b1;
          end
        end
        MODE_SET_LOW: begin
          if (hit_primary) begin
            st_nxt.pin = 1'b0;
          end
        end
        MODE_TOGGLE: begin
          if (hit_primary) begin
            st_nxt.pin = ~st_r.pin;
          end
        end
        MODE_ONE_PULSE: begin
          case (st_r.phase)
            PS_WAIT_RISE: begin
              if (hit_primary) begin
                st_nxt.pin = 1'b1;
                st_nxt.phase = PS_WAIT_FALL;
              end
            end
            PS_WAIT_FALL: begin
              if (hit_secondary) begin
                st_nxt.pin = 1'b0;
                st_nxt.phase = PS_DONE;
              end
            end
            PS_DONE: st_nxt.pin = 1'b0;
            default: st_nxt.phase = PS_WAIT_RISE;
          endcase
        end
        MODE_PULSES: begin
          if (hit_primary) begin
            st_nxt.pin = 1'b1;
          end else if (hit_secondary) begin
            st_nxt.pin = 1'b0;
          end
        end
        MODE_PWM, MODE_PWM_FAULT: begin
          // Primary match ends the high part, secondary starts it
          if (fault_on && st_r.fault_s2) begin
            st_nxt.pin = 1'b0;
          end else if (hit_primary) begin
            st_nxt.pin = 1'b0;
          end else if (hit_secondary) begin
            st_nxt.pin = 1'b1;
          end
        end
        default: st_nxt.pin = st_r.pin;
      endcase
    end

    // Fault status: set by fault, cleared by hardware once it ends
    if (fault_on && st_r.cfg.enable) begin
      st_nxt.pwm_fault_status = st_r.fault_s2;
    end else begin
      st_nxt.pwm_fault_status = 1'b0;
    end

    // Register writes; fault status has no write path
    if (wr_en) begin
      case (paddr)
        OFF_CONTROL: begin
          st_nxt.cfg.enable = pwdata[BIT_ENABLE];
          st_nxt.cfg.stop_in_idle = pwdata[BIT_STOP_IDLE];
          st_nxt.cfg.wide_compare_select = pwdata[BIT_WIDE];
          st_nxt.cfg.timebase_select = pwdata[BIT_TSEL];
          st_nxt.cfg.compare_mode = pwdata[MODE_LSB +: 3];
          // New mode re-initialises the pin
          if (pwdata[MODE_LSB +: 3] != st_r.cfg.compare_mode ||
              !st_r.cfg.enable) begin
            st_nxt.phase = PS_WAIT_RISE;
            st_nxt.pin = pwdata[MODE_LSB +: 3] == MODE_SET_LOW;
          end
        end
        OFF_PRIMARY: st_nxt.primary_compare_value = pwdata;
        OFF_SECONDARY: st_nxt.secondary_compare_value = pwdata;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.primary_compare_value <= COMPARE_RST;
      st_r.secondary_compare_value <= COMPARE_RST;
      st_r.phase <= PS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ===== pkg/ocpu_pkg.sv
// Purpose: Shared constants and types for the output compare unit
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses

package ocpu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PRIMARY = 8'h04;
  localparam logic [7:0] OFF_SECONDARY = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;

  // Control field positions
  localparam int BIT_ENABLE = 15;
  localparam int BIT_STOP_IDLE = 13;
  localparam int BIT_WIDE = 5;
  localparam int BIT_FAULT = 4;
  localparam int BIT_TSEL = 3;
  localparam int MODE_LSB = 0;

  // Reset values
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] COMPARE_RST = 32'h0000_0000;

  // Compare modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SET_HIGH = 3'h1;
  localparam logic [2:0] MODE_SET_LOW = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_ONE_PULSE = 3'h4;
  localparam logic [2:0] MODE_PULSES = 3'h5;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

  // Software configuration
  typedef struct packed {
    logic enable;
    logic stop_in_idle;
    logic wide_compare_select;
    logic timebase_select;
    logic [2:0] compare_mode;
  } ocpu_cfg_t;

  // One-shot pulse progress
  typedef enum logic [1:0] {
    PS_IDLE,
    PS_WAIT_RISE,
    PS_WAIT_FALL,
    PS_DONE
  } ocpu_phase_t;

endpackage

// ===== tb/ocpu_asserts.sv
// Purpose: Port checks for the output compare unit
// Assumes: Mode bits are shadowed from APB writes
// Notes: Bound into ocpu_top
`timescale 1ns/100ps
module ocpu_chk
  import ocpu_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timers, idle, fault and pin
  input wire logic [31:0] timer_second,
  input wire logic [31:0] timer_third,
  input wire logic cpu_idle,
  input wire logic pwm_fault_pin,
  input wire logic compare_output_pin
);
  logic [3:0][31:0] sh_r;
  logic wr, rd, hp, hs, act;
  logic [31:0] t, k;
  logic [2:0] m;
  // Shadow of writes, so the checker never peeks inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sh_r <= '0;
    else if (psel && penable && pwrite && paddr < 8'h10)
      sh_r[paddr[3:2]] <= pwdata;
  end
  // Control writes re-initialise the pin on a mode change or while disabled, so all are excluded
  assign wr = psel && penable && pwrite && paddr == OFF_CONTROL;
  assign rd = psel && !penable && !pwrite;
  assign m = sh_r[0][2:0];
  assign t = sh_r[0][BIT_TSEL] ? timer_third : timer_second;
  assign k = sh_r[0][BIT_WIDE] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  assign hp = ((t ^ sh_r[1]) & k) == 32'h0;
  assign hs = ((t ^ sh_r[2]) & k) == 32'h0;
  assign act = sh_r[0][BIT_ENABLE] && !wr &&
    !(sh_r[0][BIT_STOP_IDLE] && cpu_idle);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_en; !sh_r[0][BIT_ENABLE] && !wr |=> !compare_output_pin; endproperty
  a_en: assert property (p_en) else $error("pin high while off");
  property p_m0; act && m == MODE_OFF |=> !compare_output_pin; endproperty
  a_m0: assert property (p_m0) else $error("pin high in mode 0");
  property p_unimp; rd && paddr == OFF_CONTROL |=>
    (prdata & 32'hFFFF_5FC0) == 32'h0; endproperty
  a_unimp: assert property (p_unimp) else $error("spare bits set");
  property p_flt0; rd && paddr == OFF_CONTROL && m != MODE_PWM_FAULT
    |=> !prdata[BIT_FAULT]; endproperty
  a_flt0: assert property (p_flt0) else $error("fault bit stray");
  property p_fclr; (!pwm_fault_pin)[*4] ##0 rd && paddr == OFF_STATUS
    |=> prdata == 32'h0; endproperty
  a_fclr: assert property (p_fclr) else $error("status stuck");
  property p_fpin; (act && m == MODE_PWM_FAULT && pwm_fault_pin)[*4]
    |=> !compare_output_pin; endproperty
  a_fpin: assert property (p_fpin) else $error("fault not obeyed");
  property p_tg; act && m == MODE_TOGGLE && hp |=> $changed(compare_output_pin);
  endproperty
  a_tg: assert property (p_tg) else $error("no toggle");
  property p_hi; act && m == MODE_SET_HIGH && hp |=> compare_output_pin;
  endproperty
  a_hi: assert property (p_hi) else $error("no rise on match");
  property p_idl; sh_r[0][BIT_ENABLE] && sh_r[0][BIT_STOP_IDLE] && cpu_idle
    && !wr |=> $stable(compare_output_pin); endproperty
  a_idl: assert property (p_idl) else $error("moved in idle");
  property p_pwm; act && m == MODE_PWM && hs && !hp |=> compare_output_pin;
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm edge lost");
  c_tg: cover property (act && m == MODE_TOGGLE && hp);
  c_flt: cover property (act && m == MODE_PWM_FAULT && pwm_fault_pin);
  c_idl: cover property (sh_r[0][BIT_STOP_IDLE] && cpu_idle);
endmodule
bind ocpu_top ocpu_chk i_chk (.*);

// ===== tb/ocpu_load.sv
// Purpose: Load on the compare pin, counting pulses
// Assumes: Pin is a push-pull level
// Notes: Passive, drives nothing back
`timescale 1ns/100ps
module ocpu_load (
  // Clock and pin
  input wire logic pclk,
  input wire logic compare_output_pin,
  // Rising edges seen
  output logic [7:0] rises
);
  logic last_r = 1'h0;
  initial rises = 8'h00;
  // Edge detect on the sampled level
  always @(posedge pclk) begin
    if (compare_output_pin && !last_r) rises <= rises + 8'h01;
    last_r <= compare_output_pin;
  end
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the output compare unit
// Assumes: Zero-wait APB, pin moves one edge after a match
// Notes: Reads and pin levels are noted in queues
`timescale 1ns/100ps
module tb_top import ocpu_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, cpu_idle, pwm_fault_pin;
  logic pready, pslverr, compare_output_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, timer_second, timer_third, d;
  logic [31:0] qr[$];
  logic [7:0] rises_seen;
  logic qp[$];
  int bad_count, compares, cyc, seed;
  ocpu_top i_dut (.*);
  ocpu_load i_load (.pclk(pclk), .compare_output_pin(compare_output_pin),
    .rises(rises_seen));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One transfer; waits on pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qr.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  // One-cycle match on the chosen timer, then note the pin
  task automatic pulse(input logic s, input logic [31:0] v, input logic e);
    if (s) timer_third <= v;
    else timer_second <= v;
    @(posedge pclk);
    timer_third <= 32'h0;
    timer_second <= 32'h0;
    qp.push_back(e);
    @(posedge pclk);
  endtask
  // Reads match at the access edge; pin is looked at mid-cycle
  always @(posedge pclk)
    if (psel && penable && !pwrite && qr.size() != 0)
      cmp(prdata, qr.pop_front());
  always @(negedge pclk)
    if (qp.size() != 0) cmp({31'h0, compare_output_pin}, {31'h0, qp.pop_front()});
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    seed = 32'h0000_28d7;
    {psel, penable, pwrite, cpu_idle, pwm_fault_pin, presetn} = 6'h00;
    {paddr, pwdata, timer_second, timer_third} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(OFF_CONTROL, CONTROL_RST);
    rd(8'h10, 32'h0);
    apb(1'h1, OFF_CONTROL, 32'hFFFF_FFFF);
    rd(OFF_CONTROL, 32'h0000_A02F);
    d = $random(seed);
    apb(1'h1, OFF_PRIMARY, d);
    rd(OFF_PRIMARY, d);
    apb(1'h1, OFF_PRIMARY, 32'h0001_0005);
    // Modes 1 to 3; mode 3 runs on the third timer
    for (int i = 1; i < 4; i++) begin
      apb(1'h1, OFF_CONTROL, 32'(32'h0000_8000 + i + 8 * (i / 3)));
      qp.push_back(i == 2);
      pulse(i == 3, 32'h0000_0005, i != 2);
    end
    apb(1'h1, OFF_CONTROL, 32'h0000_8021);
    pulse(1'h0, 32'h0000_0005, 1'h0);
    pulse(1'h0, 32'h0001_0005, 1'h1);
    apb(1'h1, OFF_CONTROL, 32'h0000_A003);
    cpu_idle <= 1'h1;
    pulse(1'h0, 32'h0000_0005, 1'h0);
    cpu_idle <= 1'h0;
    pulse(1'h0, 32'h0000_0005, 1'h1);
    apb(1'h1, OFF_CONTROL, 32'h0000_0001);
    pulse(1'h0, 32'h0000_0005, 1'h0);
    apb(1'h1, OFF_CONTROL, 32'h0000_8000);
    pulse(1'h0, 32'h0000_0005, 1'h0);
    // PWM: idle timer matches the secondary value, primary ends it
    apb(1'h1, OFF_CONTROL, 32'h0000_8006);
    pwm_fault_pin <= 1'h1;
    @(posedge pclk);
    qp.push_back(1'h1);
    pulse(1'h0, 32'h0000_0005, 1'h0);
    rd(OFF_STATUS, 32'h0);
    apb(1'h1, OFF_CONTROL, 32'h0000_8007);
    repeat (4) @(posedge pclk);
    qp.push_back(1'h0);
    rd(OFF_STATUS, 32'h0000_0001);
    rd(OFF_CONTROL, 32'h0000_8017);
    pwm_fault_pin <= 1'h0;
    repeat (4) @(posedge pclk);
    rd(OFF_STATUS, 32'h0);
    apb(1'h1, OFF_CONTROL, 32'h0000_8017);
    rd(OFF_CONTROL, 32'h0000_8007);
    // Load saw every rising edge of the pin over the whole run
    cmp({24'h00_0000, rises_seen}, 32'h0000_0008);
    test_done();
  end
endmodule
